/* File: usp_pkg.sv */
// Summary of operation
// - Protocol field 01 selects user serial mode.
// - Baud field selects one of eight rates.
// - Parity field and data-width bit set framing.
// - Exactly one stop bit per character.
// - User mode only while controller runs.
// - No panel traffic on a user-mode port.
// - Separate control byte for each port.
// - Transmit buffer: count byte, then characters.
// - Transmit-complete event after last character.
// - Per-port transmit-done flag software can poll.
// - Zero count sends 16-bit-time break.
// - Break completion acts like message completion.
// - Receive buffer: count byte, up to 255.
// - Receive-complete event after last stored character.
// - Receive request starts/stops; needs start and end.
// - Bad receive parameters set terminated bit 6.
// - Port other than 0 or 1 gives 0090H.
// - Transmit/receive conflict gives 0009H or 000BH.
// - Requests refused unless port in user mode.
// - Receive status zero only while receiving.
// - Framing, parity, break end reception.
package usp_pkg;
   localparam int CLK_HZ = 250_000_000;
   localparam int OVS    = 16;
   localparam int BAUD_38400  = 38400;
   localparam int BAUD_19200  = 19200;
   localparam int BAUD_9600   = 9600;
   localparam int BAUD_4800   = 4800;
   localparam int BAUD_2400   = 2400;
   localparam int BAUD_1200   = 1200;
   localparam int BAUD_115200 = 115200;
   localparam int BAUD_57600  = 57600;

   // Register offsets
   localparam logic [3:0] A_CTRL0   = 4'h0;
   localparam logic [3:0] A_CTRL1   = 4'h1;
   localparam logic [3:0] A_CMD     = 4'h2;
   localparam logic [3:0] A_INDEX   = 4'h3;
   localparam logic [3:0] A_BUF0    = 4'h4;
   localparam logic [3:0] A_BUF1    = 4'h5;
   localparam logic [3:0] A_TXSTAT  = 4'h6;
   localparam logic [3:0] A_RXSTAT0 = 4'h7;
   localparam logic [3:0] A_RXSTAT1 = 4'h8;
   localparam logic [3:0] A_ERRLO   = 4'h9;
   localparam logic [3:0] A_ERRHI   = 4'hA;
   localparam logic [3:0] A_EVEN    = 4'hB;
   localparam logic [3:0] A_LASTEV  = 4'hC;

   // Control byte fields
   localparam int C_PAR_ODD = 7;
   localparam int C_PAR_EN  = 6;
   localparam int C_SEVEN   = 5;
   localparam int C_BAUD_HI = 4;
   localparam int C_BAUD_LO = 2;
   localparam int C_MODE_HI = 1;
   localparam int C_MODE_LO = 0;
   localparam logic [1:0] MODE_USER = 2'h1;
   localparam logic [7:0] CTRL_RST  = 8'h00;

   // Command fields
   localparam int K_RCV     = 0;
   localparam int K_EN      = 1;
   localparam int K_SC      = 2;
   localparam int K_EC      = 3;
   localparam int K_PORT_HI = 5;
   localparam int K_PORT_LO = 4;

   // Receive status bits
   localparam int RS_N = 7;
   localparam int RS_R = 6;
   localparam int RS_C = 1;
   localparam int RS_P = 0;
   localparam logic [7:0] RXSTAT_RST = 8'h80;

   // Error codes
   localparam logic [15:0] ERR_NONE     = 16'h0000;
   localparam logic [15:0] ERR_CONFL0   = 16'h0009;
   localparam logic [15:0] ERR_CONFL1   = 16'h000B;
   localparam logic [15:0] ERR_PORT     = 16'h0090;
   localparam logic [15:0] ERR_NOT_USER = 16'h0091;
   localparam logic [15:0] ERR_RX_PARAM = 16'h0092;

   // Event numbers
   localparam logic [7:0] EV_TX0 = 8'h09;
   localparam logic [7:0] EV_TX1 = 8'h1A;
   localparam logic [7:0] EV_RX0 = 8'h17;
   localparam logic [7:0] EV_RX1 = 8'h18;

   // Framing
   localparam logic [3:0] FRAME_MAX = 4'hB;
   localparam logic [3:0] FRAME_8N  = 4'hA;
   localparam logic [3:0] D7_POS    = 4'h7;
   localparam logic [3:0] D8_POS    = 4'h8;
   localparam logic [7:0] BRK_BITS  = 8'h10;
   localparam logic [7:0] MAX_CHARS = 8'hFF;
   localparam logic [3:0] SUB_LAST  = 4'(OVS - 1);
   localparam logic [3:0] SUB_MID   = 4'(OVS / 2 - 1);

   typedef enum logic [3:0] {
      TX_IDLE  = 4'b0001,
      TX_LOAD  = 4'b0010,
      TX_SHIFT = 4'b0100,
      TX_BRK   = 4'b1000
   } usp_tx_t;

   typedef enum logic [2:0] {
      RX_OFF  = 3'b001,
      RX_HUNT = 3'b010,
      RX_BIT  = 3'b100
   } usp_rx_t;

   function automatic logic [15:0] usp_div(input logic [2:0] sel);
      int rate;
      unique case (sel)
         3'h0: rate = BAUD_38400;
         3'h1: rate = BAUD_19200;
         3'h2: rate = BAUD_9600;
         3'h3: rate = BAUD_4800;
         3'h4: rate = BAUD_2400;
         3'h5: rate = BAUD_1200;
         3'h6: rate = BAUD_115200;
         3'h7: rate = BAUD_57600;
      endcase
      return 16'(CLK_HZ / (OVS * rate) - 1);
   endfunction : usp_div
endpackage : usp_pkg

/* File: usp_uart.sv */
`timescale 1ns/1ps
module usp_port #(
   parameter int DEPTH = 256
) (
   input  wire logic       clk_in,
   input  wire logic       rst_in,
   input  wire logic       ce_in,
   input  wire logic       user_in,
   input  wire logic [7:0] ctrl_in,
   input  wire logic       ev_tx_en_in,
   input  wire logic       ev_rx_en_in,
   input  wire logic       send_in,
   input  wire logic       rcv_on_in,
   input  wire logic       rcv_off_in,
   input  wire logic       rcv_bad_in,
   input  wire logic       bw_in,
   input  wire logic [7:0] bidx_in,
   input  wire logic [7:0] bdat_in,
   input  wire logic       rxd_in,
   output logic            txd_out,
   output logic            tx_done_out,
   output logic            tx_busy_out,
   output logic            rx_act_out,
   output logic [7:0]      rx_stat_out,
   output logic            tx_ev_out,
   output logic            rx_ev_out,
   output logic [7:0]      rdat_out
);
   typedef struct packed {
      usp_pkg::usp_tx_t         tx;
      usp_pkg::usp_rx_t         rx;
      logic [15:0]              tdiv;
      logic [3:0]               tsub;
      logic [7:0]               tbits;
      logic [11:0]              tsh;
      logic [7:0]               tcnt;
      logic [7:0]               tptr;
      logic [15:0]              rdiv;
      logic [3:0]               rsub;
      logic [3:0]               rbit;
      logic [9:0]               rsh;
      logic [7:0]               rcnt;
      logic                     txd;
      logic                     done;
      logic                     tev;
      logic                     rev;
      logic [7:0]               rstat;
      logic [DEPTH-1:0][7:0]    tbuf;
      logic [DEPTH-1:0][7:0]    rbuf;
   } usp_port_st_t;

   usp_port_st_t s;
   usp_port_st_t next_s;

   function automatic logic [11:0] usp_frame(input logic [7:0] d, input logic sev, input logic pen,
                                              input logic odd);
      logic [11:0] f;
      logic        p;
      p = (^(sev ? {1'b0, d[6:0]} : d)) ^ odd;
      f = {3'b111, d, 1'b0};
      if (sev) begin
         f[usp_pkg::D8_POS] = 1'b1;
      end
      if (pen) begin
         if (sev) begin
            f[usp_pkg::D8_POS] = p;
         end else begin
            f[usp_pkg::D8_POS + 4'h1] = p;
         end
      end
      return f;
   endfunction : usp_frame

   logic [15:0] div;
   logic        sev;
   logic        pen;
   logic        odd;
   logic [3:0]  fb;
   logic [9:0]  nw;
   logic [9:0]  w;
   logic [7:0]  dat;
   logic        par;
   logic        stp;
   logic [7:0]  cnt1;

   always_comb begin
      next_s = s;
      next_s.tev = 1'b0;
      next_s.rev = 1'b0;
      div  = usp_pkg::usp_div(ctrl_in[usp_pkg::C_BAUD_HI:usp_pkg::C_BAUD_LO]);
      sev  = ctrl_in[usp_pkg::C_SEVEN];
      pen  = ctrl_in[usp_pkg::C_PAR_EN];
      odd  = ctrl_in[usp_pkg::C_PAR_ODD];
      fb   = usp_pkg::FRAME_8N - {3'h0, sev} + {3'h0, pen};
      nw   = {rxd_in, s.rsh[9:1]};
      w    = nw >> (usp_pkg::FRAME_MAX - fb);
      dat  = sev ? {1'b0, w[6:0]} : w[7:0];
      par  = sev ? w[usp_pkg::D7_POS] : w[usp_pkg::D8_POS];
      stp  = w[(sev ? usp_pkg::D7_POS : usp_pkg::D8_POS) + {3'h0, pen}];
      cnt1 = s.rcnt + 8'h01;
      if (bw_in) begin
         next_s.tbuf[bidx_in] = bdat_in;
      end

      unique case (s.tx)
         usp_pkg::TX_IDLE: begin
            if (send_in) begin
               next_s.done = 1'b0;
               next_s.tcnt = s.tbuf[0];
               next_s.tptr = 8'h01;
               next_s.tdiv = div;
               next_s.tsub = 4'h0;
               if (s.tbuf[0] == 8'h00) begin
                  next_s.tx    = usp_pkg::TX_BRK;
                  next_s.txd   = 1'b0;
                  next_s.tbits = usp_pkg::BRK_BITS;
               end else begin
                  next_s.tx = usp_pkg::TX_LOAD;
               end
            end
         end
         usp_pkg::TX_LOAD: begin
            next_s.tsh   = usp_frame(s.tbuf[s.tptr], sev, pen, odd) >> 1;
            next_s.txd   = 1'b0;
            next_s.tbits = {4'h0, fb};
            next_s.tdiv  = div;
            next_s.tsub  = 4'h0;
            next_s.tx    = usp_pkg::TX_SHIFT;
         end
         usp_pkg::TX_SHIFT, usp_pkg::TX_BRK: begin
            if (s.tdiv == 16'h0000) begin
               next_s.tdiv = div;
               next_s.tsub = s.tsub + 4'h1;
               if (s.tsub == usp_pkg::SUB_LAST) begin
                  next_s.tbits = s.tbits - 8'h01;
                  if (s.tbits == 8'h01) begin
                     if (s.tx == usp_pkg::TX_BRK || s.tcnt == 8'h01) begin
                        next_s.txd  = 1'b1;
                        next_s.tx   = usp_pkg::TX_IDLE;
                        next_s.done = 1'b1;
                        next_s.tev  = ev_tx_en_in;
                     end else begin
                        next_s.tcnt = s.tcnt - 8'h01;
                        next_s.tptr = s.tptr + 8'h01;
                        next_s.tx   = usp_pkg::TX_LOAD;
                     end
                  end else if (s.tx == usp_pkg::TX_SHIFT) begin
                     next_s.txd = s.tsh[0];
                     next_s.tsh = s.tsh >> 1;
                  end
               end
            end else begin
               next_s.tdiv = s.tdiv - 16'h0001;
            end
         end
      endcase

      unique case (s.rx)
         usp_pkg::RX_OFF: begin
         end
         usp_pkg::RX_HUNT: begin
            if (!rxd_in) begin
               next_s.rdiv = div;
               next_s.rsub = 4'h0;
               next_s.rbit = 4'h0;
               next_s.rx   = usp_pkg::RX_BIT;
            end
         end
         usp_pkg::RX_BIT: begin
            if (s.rdiv == 16'h0000) begin
               next_s.rdiv = div;
               next_s.rsub = s.rsub + 4'h1;
               if (s.rsub == usp_pkg::SUB_MID) begin
                  next_s.rbit = s.rbit + 4'h1;
                  next_s.rsh  = nw;
                  if (s.rbit == 4'h0 && rxd_in) begin
                     next_s.rx = usp_pkg::RX_HUNT;
                  end else if (s.rbit == fb - 4'h1) begin
                     if (!stp || (pen && (par != ((^dat) ^ odd)))) begin
                        next_s.rx    = usp_pkg::RX_OFF;
                        next_s.rstat = 8'h00;
                        next_s.rstat[usp_pkg::RS_P] = 1'b1;
                     end else begin
                        next_s.rbuf[cnt1] = dat;
                        next_s.rbuf[0]    = cnt1;
                        next_s.rcnt       = cnt1;
                        if (cnt1 == usp_pkg::MAX_CHARS) begin
                           next_s.rx    = usp_pkg::RX_OFF;
                           next_s.rstat = 8'h00;
                           next_s.rstat[usp_pkg::RS_C] = 1'b1;
                           next_s.rev   = ev_rx_en_in;
                        end else begin
                           next_s.rx = usp_pkg::RX_HUNT;
                        end
                     end
                  end
               end
            end else begin
               next_s.rdiv = s.rdiv - 16'h0001;
            end
         end
      endcase

      if (rcv_on_in) begin
         next_s.rx    = usp_pkg::RX_HUNT;
         next_s.rstat = 8'h00;
         next_s.rcnt  = 8'h00;
         next_s.rbuf[0] = 8'h00;
      end
      if (rcv_off_in || (!user_in && s.rx != usp_pkg::RX_OFF)) begin
         next_s.rx    = usp_pkg::RX_OFF;
         next_s.rstat = 8'h00;
         next_s.rstat[usp_pkg::RS_N] = 1'b1;
      end
      if (rcv_bad_in) begin
         next_s.rx    = usp_pkg::RX_OFF;
         next_s.rstat = 8'h00;
         next_s.rstat[usp_pkg::RS_R] = 1'b1;
      end
      if (!user_in) begin
         next_s.tx  = usp_pkg::TX_IDLE;
         next_s.txd = 1'b1;
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         s       <= '0;
         s.tx    <= usp_pkg::TX_IDLE;
         s.rx    <= usp_pkg::RX_OFF;
         s.txd   <= 1'b1;
         s.rstat <= usp_pkg::RXSTAT_RST;
      end else if (ce_in) begin
         s <= next_s;
      end
   end

   assign txd_out     = s.txd;
   assign tx_done_out = s.done;
   assign tx_busy_out = s.tx != usp_pkg::TX_IDLE;
   assign rx_act_out  = s.rx != usp_pkg::RX_OFF;
   assign rx_stat_out = s.rstat;
   assign tx_ev_out   = s.tev;
   assign rx_ev_out   = s.rev;
   assign rdat_out    = s.rbuf[bidx_in];
endmodule : usp_port

module usp_uart #(
   parameter int DEPTH = 256
) (
   input  wire logic       clk_in,
   input  wire logic       rst_in,
   input  wire logic       ce_in,
   input  wire logic       run_in,
   input  wire logic [3:0] addr_in,
   input  wire logic [7:0] wdata_in,
   input  wire logic       wr_in,
   input  wire logic       rd_in,
   input  wire logic [1:0] rxd_in,
   output logic [7:0]      rdata_out,
   output logic [1:0]      txd_out,
   output logic [1:0]      tx_event_out,
   output logic [1:0]      rx_event_out,
   output logic [1:0]      user_mode_out,
   output logic [1:0]      panel_en_out,
   output logic            cmd_ok_out
);
   typedef struct packed {
      logic [1:0][7:0] ctl;
      logic [7:0]      idx;
      logic [3:0]      even;
      logic [15:0]     err;
      logic            ok;
      logic [7:0]      rdata;
      logic [1:0]      um;
      logic [1:0]      pan;
      logic [7:0]      lastev;
   } usp_top_st_t;

   usp_top_st_t s;
   usp_top_st_t next_s;
   logic [1:0]      send;
   logic [1:0]      ron;
   logic [1:0]      roff;
   logic [1:0]      rbad;
   logic [1:0]      bw;
   logic [1:0]      done;
   logic [1:0]      busy;
   logic [1:0]      ract;
   logic [1:0]      tev;
   logic [1:0]      rev;
   logic [1:0][7:0] rstat;
   logic [1:0][7:0] rdat;
   logic [1:0]      p;

   always_comb begin
      next_s = s;
      send = 2'h0;
      ron  = 2'h0;
      roff = 2'h0;
      rbad = 2'h0;
      bw   = 2'h0;
      p    = wdata_in[usp_pkg::K_PORT_HI:usp_pkg::K_PORT_LO];
      for (int i = 0; i < 2; i++) begin
         next_s.um[i]  = run_in &&
                         s.ctl[i][usp_pkg::C_MODE_HI:usp_pkg::C_MODE_LO] == usp_pkg::MODE_USER;
         next_s.pan[i] = !next_s.um[i];
      end
      if (tev[0]) begin
         next_s.lastev = usp_pkg::EV_TX0;
      end
      if (tev[1]) begin
         next_s.lastev = usp_pkg::EV_TX1;
      end
      if (rev[0]) begin
         next_s.lastev = usp_pkg::EV_RX0;
      end
      if (rev[1]) begin
         next_s.lastev = usp_pkg::EV_RX1;
      end
      next_s.rdata = 8'h00;
      if (wr_in) begin
         unique case (addr_in)
            usp_pkg::A_CTRL0: next_s.ctl[0] = wdata_in;
            usp_pkg::A_CTRL1: next_s.ctl[1] = wdata_in;
            usp_pkg::A_INDEX: next_s.idx = wdata_in;
            usp_pkg::A_EVEN:  next_s.even = wdata_in[3:0];
            usp_pkg::A_BUF0, usp_pkg::A_BUF1: begin
               bw[addr_in[0]] = 1'b1;
               next_s.idx = s.idx + 8'h01;
            end
            usp_pkg::A_CMD: begin
               next_s.ok  = 1'b0;
               next_s.err = usp_pkg::ERR_NONE;
               if (wdata_in[usp_pkg::K_PORT_HI]) begin
                  next_s.err = usp_pkg::ERR_PORT;
               end else if (!s.um[p[0]]) begin
                  next_s.err = usp_pkg::ERR_NOT_USER;
               end else if (!wdata_in[usp_pkg::K_RCV]) begin
                  if (busy[p[0]] || ract[p[0]]) begin
                     next_s.err = p[0] ? usp_pkg::ERR_CONFL1 : usp_pkg::ERR_CONFL0;
                  end else begin
                     send[p[0]] = 1'b1;
                     next_s.ok  = 1'b1;
                  end
               end else if (!wdata_in[usp_pkg::K_EN]) begin
                  roff[p[0]] = 1'b1;
                  next_s.ok  = 1'b1;
               end else if (busy[p[0]]) begin
                  next_s.err = p[0] ? usp_pkg::ERR_CONFL1 : usp_pkg::ERR_CONFL0;
               end else if (!(wdata_in[usp_pkg::K_SC] && wdata_in[usp_pkg::K_EC])) begin
                  rbad[p[0]] = 1'b1;
                  next_s.err = usp_pkg::ERR_RX_PARAM;
               end else begin
                  ron[p[0]] = 1'b1;
                  next_s.ok = 1'b1;
               end
            end
            default: begin
            end
         endcase
      end
      if (rd_in) begin
         unique case (addr_in)
            usp_pkg::A_CTRL0:   next_s.rdata = s.ctl[0];
            usp_pkg::A_CTRL1:   next_s.rdata = s.ctl[1];
            usp_pkg::A_INDEX:   next_s.rdata = s.idx;
            usp_pkg::A_TXSTAT:  next_s.rdata = {4'h0, busy, done};
            usp_pkg::A_RXSTAT0: next_s.rdata = rstat[0];
            usp_pkg::A_RXSTAT1: next_s.rdata = rstat[1];
            usp_pkg::A_ERRLO:   next_s.rdata = s.err[7:0];
            usp_pkg::A_ERRHI:   next_s.rdata = s.err[15:8];
            usp_pkg::A_EVEN:    next_s.rdata = {4'h0, s.even};
            usp_pkg::A_LASTEV:  next_s.rdata = s.lastev;
            usp_pkg::A_BUF0, usp_pkg::A_BUF1: begin
               next_s.rdata = rdat[addr_in[0]];
               next_s.idx   = s.idx + 8'h01;
            end
            default:            next_s.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         s        <= '0;
         s.ctl[0] <= usp_pkg::CTRL_RST;
         s.ctl[1] <= usp_pkg::CTRL_RST;
         s.pan    <= 2'h3;
      end else if (ce_in) begin
         s <= next_s;
      end
   end

   for (genvar g = 0; g < 2; g++) begin : g_port
      usp_port #(.DEPTH(DEPTH)) u_port (
         .clk_in      (clk_in),
         .rst_in      (rst_in),
         .ce_in       (ce_in),
         .user_in     (s.um[g]),
         .ctrl_in     (s.ctl[g]),
         .ev_tx_en_in (s.even[g]),
         .ev_rx_en_in (s.even[g+2]),
         .send_in     (send[g]),
         .rcv_on_in   (ron[g]),
         .rcv_off_in  (roff[g]),
         .rcv_bad_in  (rbad[g]),
         .bw_in       (bw[g]),
         .bidx_in     (s.idx),
         .bdat_in     (wdata_in),
         .rxd_in      (rxd_in[g]),
         .txd_out     (txd_out[g]),
         .tx_done_out (done[g]),
         .tx_busy_out (busy[g]),
         .rx_act_out  (ract[g]),
         .rx_stat_out (rstat[g]),
         .tx_ev_out   (tev[g]),
         .rx_ev_out   (rev[g]),
         .rdat_out    (rdat[g])
      );
   end

   assign tx_event_out  = tev;
   assign rx_event_out  = rev;
   assign rdata_out     = s.rdata;
   assign user_mode_out = s.um;
   assign panel_en_out  = s.pan;
   assign cmd_ok_out    = s.ok;
endmodule : usp_uart

/* File: usp_uart_assertions.sv */
`timescale 1ns/1ps
module usp_uart_assertions (
   input wire logic       clk_in,
   input wire logic       rst_in,
   input wire logic       ce_in,
   input wire logic       run_in,
   input wire logic [3:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic       wr_in,
   input wire logic       rd_in,
   input wire logic [7:0] rdata_out,
   input wire logic [1:0] txd_out,
   input wire logic [1:0] tx_event_out,
   input wire logic [1:0] user_mode_out,
   input wire logic [1:0] panel_en_out,
   input wire logic       cmd_ok_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);
   panel_off_a: assert property (panel_en_out == ~user_mode_out) else $error("panel on in user mode");
   run_drop_a: assert property (!run_in && ce_in |=> user_mode_out == 2'h0) else $error("user mode kept");
   rd_idle_a: assert property (ce_in && !rd_in |=> rdata_out == 8'h00) else $error("stale read data");
   rd_hole_a: assert property (rd_in && addr_in > 4'hC |=> rdata_out == 8'h00) else $error("hole read");
   tx_pulse_a: assert property (tx_event_out[0] |=> !tx_event_out[0]) else $error("event too long");
   done_mark_a: assert property (tx_event_out[0] |-> txd_out[0]) else $error("line low at end");
   start_bit_a: assert property ($fell(txd_out[0]) |=> !txd_out[0] [*8]) else $error("short start");
   bad_port_a: assert property (wr_in && addr_in == 4'h2 && wdata_in[5] |-> ##[1:2] !cmd_ok_out)
      else $error("bad port taken");
   not_user_a: assert property (wr_in && addr_in == 4'h2 && wdata_in[5:4] == 2'h1 && !user_mode_out[1]
      |-> ##[1:2] !cmd_ok_out) else $error("port not in user mode");
endmodule : usp_uart_assertions

bind usp_uart usp_uart_assertions i_usp_uart_assertions (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in),
   .run_in(run_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
   .rdata_out(rdata_out), .txd_out(txd_out), .tx_event_out(tx_event_out), .user_mode_out(user_mode_out),
   .panel_en_out(panel_en_out), .cmd_ok_out(cmd_ok_out));

/* File: usp_serial_peer.sv */
`timescale 1ns/1ps
module usp_serial_peer #(
   parameter int BIT = 2160
) (
   input  wire logic       clk_in,
   input  wire logic       txd_in,
   input  wire logic       go_in,
   input  wire logic [7:0] byte_in,
   input  wire logic       bad_in,
   output logic            rxd_out,
   output logic [8:0]      got_out,
   output int              low_out
);
   int         run = 0;
   logic [10:0] f;
   initial begin
      rxd_out = 1'b1;
      low_out = 0;
      forever begin
         @(posedge go_in);
         f = {1'b1, ^byte_in ^ bad_in, byte_in, 1'b0};
         for (int i = 0; i < 11; i++) begin
            rxd_out <= f[i];
            repeat (BIT) @(posedge clk_in);
         end
      end
   end
   initial begin
      got_out = 9'h000;
      forever begin
         @(negedge txd_in);
         repeat (BIT / 2) @(posedge clk_in);
         for (int i = 0; i < 9; i++) begin
            repeat (BIT) @(posedge clk_in);
            got_out[i] = txd_in;
         end
         repeat (BIT) @(posedge clk_in);
      end
   end
   // Longest low run, used to time a break
   always @(posedge clk_in) begin
      run <= txd_in ? 0 : run + 1;
      if (!txd_in && run + 1 > low_out) low_out <= run + 1;
   end
endmodule : usp_serial_peer

/* File: usp_uart_tb_top.sv */
`timescale 1ns/1ps
module usp_uart_tb_top;
   localparam int BIT = 16 * (250_000_000 / (16 * 115200));
   logic       clk_in = 1'b0;
   logic       rst_in = 1'b1;
   logic       run_in = 1'b1;
   logic       ce_in = 1'b1;
   logic [3:0] addr_in = 4'h0;
   logic [7:0] wdata_in = 8'h00;
   logic       wr_in = 1'b0;
   logic       rd_in = 1'b0;
   logic       go = 1'b0;
   logic       prx;
   logic [7:0] rdata_out, ch;
   logic [1:0] txd_out, tx_event_out, rx_event_out, user_mode_out, panel_en_out;
   logic       cmd_ok_out;
   logic [8:0] got;
   int         low, fail_count = 0, checks = 0, cyc = 0, rx_seen = 0;
   usp_uart i_usp_uart (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .run_in(run_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rxd_in({prx, 1'b1}), .rdata_out(rdata_out),
      .txd_out(txd_out), .tx_event_out(tx_event_out), .rx_event_out(rx_event_out),
      .user_mode_out(user_mode_out), .panel_en_out(panel_en_out), .cmd_ok_out(cmd_ok_out));
   usp_serial_peer #(.BIT(BIT)) i_usp_serial_peer (.clk_in(clk_in), .txd_in(txd_out[0]), .go_in(go),
      .byte_in(ch), .bad_in(1'b1), .rxd_out(prx), .got_out(got), .low_out(low));
   initial begin
      forever #2 clk_in = ~clk_in;
   end
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (rx_event_out !== 2'h0) rx_seen <= rx_seen + 1;
      if (cyc == 80000) begin
         fail_count++;
         final_report();
      end
   end
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      checks++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH %s exp %h got %h", n, e, g);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_in);
      wr_in <= 1'b1;
      addr_in <= a;
      wdata_in <= d;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [7:0] e, input string n);
      @(posedge clk_in);
      rd_in <= 1'b1;
      addr_in <= a;
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1 chk(n, {8'h00, e}, {8'h00, rdata_out});
   endtask : rd
   task automatic wait_ev(input int lim);
      int k;
      k = 0;
      do begin
         @(posedge clk_in);
         #1 k++;
      end while (tx_event_out[0] !== 1'b1 && k < lim);
      chk("tx event", 16'h0001, {15'h0, tx_event_out[0]});
   endtask : wait_ev
   task automatic final_report();
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : final_report
   initial begin
      void'($urandom(9));
      ch = 8'($urandom());
      repeat (20) @(posedge clk_in);
      rst_in <= 1'b0;
      rd(4'h7, 8'h80, "rx status reset");
      rd(4'h6, 8'h00, "tx status reset");
      for (int m = 0; m < 4; m++) begin
         wr(4'h0, 8'h58 | 8'(m));
         @(posedge clk_in);
         #1 chk("user mode", {15'h0, m == 1}, {14'h0, user_mode_out});
         chk("panel", {14'h0, 1'b1, m != 1}, {14'h0, panel_en_out});
      end
      rd(4'h0, 8'h5B, "control byte");
      wr(4'h2, 8'h10);
      rd(4'h9, 8'h91, "not user error");
      wr(4'h2, 8'h20);
      rd(4'h9, 8'h90, "port error");
      rd(4'hF, 8'h00, "hole");
      wr(4'h0, 8'h59);
      wr(4'h1, 8'h59);
      wr(4'hB, 8'h0F);
      wr(4'h2, 8'h07);
      rd(4'h7, 8'h40, "rx param");
      rd(4'h9, 8'h92, "rx param error");
      wr(4'h2, 8'h1F);
      rd(4'h8, 8'h00, "rx active");
      wr(4'h2, 8'h10);
      rd(4'h9, 8'h0B, "conflict");
      wr(4'h3, 8'h00);
      wr(4'h4, 8'h01);
      wr(4'h4, ch);
      wr(4'h2, 8'h00);
      go <= 1'b1;
      wait_ev(30000);
      chk("tx char", {7'h0, ^ch, ch}, {7'h0, got});
      rd(4'h6, 8'h01, "tx done");
      rd(4'hC, 8'h09, "last event");
      repeat (BIT) @(posedge clk_in);
      rd(4'h8, 8'h01, "rx parity stop");
      wr(4'h3, 8'h00);
      wr(4'h4, 8'h00);
      wr(4'h2, 8'h00);
      wait_ev(40000);
      chk("break", 16'h0001, {15'h0, low >= 16 * BIT && low < 17 * BIT});
      rd(4'h6, 8'h01, "break done");
      @(posedge clk_in);
      ce_in  <= 1'b0;
      run_in <= 1'b0;
      repeat (3) @(posedge clk_in);
      #1 chk("frozen mode", 16'h0003, {14'h0, user_mode_out});
      @(posedge clk_in);
      ce_in <= 1'b1;
      repeat (3) @(posedge clk_in);
      #1 chk("stop mode", 16'h0000, {14'h0, user_mode_out});
      chk("rx events", 16'h0000, 16'(rx_seen));
      final_report();
   end
endmodule : usp_uart_tb_top
